//--- design/cms_loss_sel_decode.sv
// Assembles each input's split signal-loss selector and registers the
// resulting monitor enables for the four input clocks.
// Assumes the selector halves come straight from register flip-flops.
`timescale 1ns/1ps
`default_nettype none

module cms_loss_sel_decode
   import cms_pkg::*;
(
   input  wire logic            i_clk,
   input  wire logic            i_rst_b,
   input  wire logic [3:0]      i_sel_high,
   input  wire logic [3:0]      i_sel_low,
   input  wire logic [3:0]      i_fos_en,
   output var  cms_mon_cfg_type o_cfg
);

   // -----------------------------------------------------------------------
   // Decode and register
   // -----------------------------------------------------------------------

   // High half joins low half per input; normal and slow are exclusive.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_cfg.los_normal_en <= 4'hf;
         o_cfg.los_slow_en   <= 4'h0;
         o_cfg.fos_en        <= 4'hf;
      end else begin
         for (int n = 0; n < CMS_NUM_INPUTS; n++) begin
            o_cfg.los_normal_en[n] <= (cms_decode_sel(
               {i_sel_high[n], i_sel_low[n]}) == CMS_MODE_NORMAL);
            o_cfg.los_slow_en[n]   <= (cms_decode_sel(
               {i_sel_high[n], i_sel_low[n]}) == CMS_MODE_SLOW);
         end
         o_cfg.fos_en <= i_fos_en;
      end
   end

   // -----------------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------------

   sel_normal_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_sel_high[0] && i_sel_low[0]) |=> o_cfg.los_normal_en[0])
      else $error("Selector 11 did not enable the normal detector.");

   sel_slow_only_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (o_cfg.los_slow_en & o_cfg.los_normal_en) == 4'h0)
      else $error("Slow and normal detectors enabled together.");

   sel_off_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      !i_sel_high[1]
      |=> !o_cfg.los_slow_en[1] && !o_cfg.los_normal_en[1])
      else $error("Selector with low upper bit left a detector on.");

endmodule : cms_loss_sel_decode

`default_nettype wire

//--- design/cms_pkg.sv
// Constants, carrier types and a helper function for the clock-monitor and
// output phase-trim configuration registers.
// Assumes an 8-bit register address and data path inside the device.

package cms_pkg;

   // ----------------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------------
   localparam logic [7:0] CMS_FAST_ACQ_ADDR   = 8'h89;
   localparam logic [7:0] CMS_SEL_HIGH_ADDR   = 8'h8a;
   localparam logic [7:0] CMS_SEL_LOW_ADDR    = 8'h8b;
   localparam logic [7:0] CMS_TRIM1_ADDR      = 8'h8c;
   localparam logic [7:0] CMS_TRIM2_ADDR      = 8'h8d;

   // ----------------------------------------------------------------------
   // Reset values and a zero byte
   // ----------------------------------------------------------------------
   localparam logic [7:0] CMS_FAST_ACQ_RST    = 8'h00;
   localparam logic [3:0] CMS_SEL_HIGH_RST    = 4'hf;
   localparam logic [7:0] CMS_SEL_LOW_RST     = 8'hff;
   localparam logic [7:0] CMS_TRIM1_RST       = 8'h00;
   localparam logic [7:0] CMS_TRIM2_RST       = 8'h01;
   localparam logic [7:0] CMS_ZERO_BYTE       = 8'h00;

   // ----------------------------------------------------------------------
   // Field positions and input count
   // ----------------------------------------------------------------------
   localparam int CMS_FAST_ACQ_BIT = 0;
   localparam int CMS_SEL_HIGH_LSB = 0;
   localparam int CMS_SEL_LOW_LSB  = 4;
   localparam int CMS_FOS_LSB      = 0;
   localparam int CMS_NUM_INPUTS   = 4;

   // ----------------------------------------------------------------------
   // Signal-loss selector codes
   // ----------------------------------------------------------------------
   localparam logic [1:0] CMS_SEL_OFF    = 2'h0;
   localparam logic [1:0] CMS_SEL_RSVD   = 2'h1;
   localparam logic [1:0] CMS_SEL_SLOW   = 2'h2;
   localparam logic [1:0] CMS_SEL_NORMAL = 2'h3;

   typedef enum logic [1:0] {
      CMS_MODE_OFF,
      CMS_MODE_SLOW,
      CMS_MODE_NORMAL
   } cms_loss_mode_type;

   // Register access request, one per cycle.
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cms_reg_req_type;

   // Per-input monitor enables, bit n for input n+1.
   typedef struct packed {
      logic [3:0] los_normal_en;
      logic [3:0] los_slow_en;
      logic [3:0] fos_en;
   } cms_mon_cfg_type;

   // Decodes one two-bit selector; the reserved code falls back to off.
   function automatic cms_loss_mode_type cms_decode_sel(
      input logic [1:0] sel
   );
      cms_loss_mode_type mode;
      mode = CMS_MODE_OFF;
      case (sel)
         CMS_SEL_SLOW:   mode = CMS_MODE_SLOW;
         CMS_SEL_NORMAL: mode = CMS_MODE_NORMAL;
         default:        mode = CMS_MODE_OFF;
      endcase
      return mode;
   endfunction : cms_decode_sel

endpackage : cms_pkg

//--- design/cms_regs.sv
// Configuration registers for fast acquisition, per-input signal-loss and
// frequency-offset monitor enables, and output one and two phase trims.
// Assumes the serial management port delivers one decoded access per
// cycle, synchronous to i_clk, and that read data is taken one cycle later.
`timescale 1ns/1ps
`default_nettype none

module cms_regs
   import cms_pkg::*;
(
   input  wire logic                i_clk,
   input  wire logic                i_rst_b,
   input  wire cms_reg_req_type     i_req,
   output var  logic [7:0]          o_reg_rdata,
   output var  logic                o_reg_rvalid,
   output var  logic                o_fast_acquire_enable,
   output var  cms_mon_cfg_type     o_mon_cfg,
   output var  logic signed [7:0]   o_output1_phase_trim,
   output var  logic signed [7:0]   o_output2_phase_trim,
   output var  logic [1:0]          o_phase_trim_load
);

   // -----------------------------------------------------------------------
   // Storage
   // -----------------------------------------------------------------------
   logic       fast_acquire_q;
   logic [3:0] sel_high_q;
   logic [7:0] sel_low_fos_q;
   logic [7:0] trim1_q;
   logic [7:0] trim2_q;
   logic [7:0] rdata_d;
   logic [1:0] trim_load_d;

   // Write strobe for one register offset.
   function automatic logic wr_hit(
      input cms_reg_req_type req,
      input logic [7:0]      addr
   );
      return req.wr && (req.addr == addr);
   endfunction : wr_hit

   // -----------------------------------------------------------------------
   // Fast acquisition
   // -----------------------------------------------------------------------

   // Only bit 0 is storage; upper bits are not kept.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         fast_acquire_q <= CMS_FAST_ACQ_RST[CMS_FAST_ACQ_BIT];
      end else if (wr_hit(i_req, CMS_FAST_ACQ_ADDR)) begin
         fast_acquire_q <= i_req.wdata[CMS_FAST_ACQ_BIT];
      end
   end

   // The loop-bandwidth controller widens its bandwidth while this is high.
   assign o_fast_acquire_enable = fast_acquire_q;

   // -----------------------------------------------------------------------
   // Signal-loss selector halves and offset-monitor enables
   // -----------------------------------------------------------------------

   // Upper selector bits live in the low nibble; upper nibble is reserved.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sel_high_q <= CMS_SEL_HIGH_RST;
      end else if (wr_hit(i_req, CMS_SEL_HIGH_ADDR)) begin
         sel_high_q <= i_req.wdata[CMS_SEL_HIGH_LSB +: 4];
      end
   end

   // Lower selector bits in 7:4, offset-monitor enables in 3:0.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sel_low_fos_q <= CMS_SEL_LOW_RST;
      end else if (wr_hit(i_req, CMS_SEL_LOW_ADDR)) begin
         sel_low_fos_q <= i_req.wdata;
      end
   end

   // Joins the split selector and registers the monitor enables.
   cms_loss_sel_decode u_decode (
      .i_clk      (i_clk),
      .i_rst_b    (i_rst_b),
      .i_sel_high (sel_high_q),
      .i_sel_low  (sel_low_fos_q[CMS_SEL_LOW_LSB +: 4]),
      .i_fos_en   (sel_low_fos_q[CMS_FOS_LSB +: 4]),
      .o_cfg      (o_mon_cfg)
   );

   // -----------------------------------------------------------------------
   // Output phase trims
   // -----------------------------------------------------------------------

   // Each trim is held as a full signed byte.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         trim1_q <= CMS_TRIM1_RST;
      end else if (wr_hit(i_req, CMS_TRIM1_ADDR)) begin
         trim1_q <= i_req.wdata;
      end
   end

   // Output two comes up one divider clock late.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         trim2_q <= CMS_TRIM2_RST;
      end else if (wr_hit(i_req, CMS_TRIM2_ADDR)) begin
         trim2_q <= i_req.wdata;
      end
   end

   assign o_output1_phase_trim = $signed(trim1_q);
   assign o_output2_phase_trim = $signed(trim2_q);

   // A write tells the output divider to re-apply its trim, counted in
   // high-speed divider clocks, to that output alone.
   always_comb begin
      trim_load_d[0] = wr_hit(i_req, CMS_TRIM1_ADDR);
      trim_load_d[1] = wr_hit(i_req, CMS_TRIM2_ADDR);
   end

   // Load pulses line up with the cycle the new trim first shows.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_phase_trim_load <= 2'h0;
      end else begin
         o_phase_trim_load <= trim_load_d;
      end
   end

   // -----------------------------------------------------------------------
   // Read-back
   // -----------------------------------------------------------------------

   // Reserved bits and unmapped offsets read as zero.
   always_comb begin
      rdata_d = CMS_ZERO_BYTE;
      if (i_req.addr == CMS_FAST_ACQ_ADDR) begin
         rdata_d[CMS_FAST_ACQ_BIT] = fast_acquire_q;
      end else if (i_req.addr == CMS_SEL_HIGH_ADDR) begin
         rdata_d[CMS_SEL_HIGH_LSB +: 4] = sel_high_q;
      end else if (i_req.addr == CMS_SEL_LOW_ADDR) begin
         rdata_d = sel_low_fos_q;
      end else if (i_req.addr == CMS_TRIM1_ADDR) begin
         rdata_d = trim1_q;
      end else if (i_req.addr == CMS_TRIM2_ADDR) begin
         rdata_d = trim2_q;
      end
   end

   // Read data holds until the next read; valid is a one-cycle pulse.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_reg_rdata  <= CMS_ZERO_BYTE;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rvalid <= i_req.rd;
         if (i_req.rd) begin
            o_reg_rdata <= rdata_d;
         end
      end
   end

   // -----------------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------------

   // Every check below runs on the register clock and rests while reset
   // is low, except the reset-value checks that look at the release edge.
   default clocking cb @(posedge i_clk);
   endclocking

   default disable iff (!i_rst_b);

   fast_acq_write_a: assert property (
      wr_hit(i_req, CMS_FAST_ACQ_ADDR)
      |=> o_fast_acquire_enable == $past(i_req.wdata[0]))
      else $error("Fast acquisition did not follow the written bit.");

   fast_acq_reset_a: assert property (disable iff (1'b0)
      $rose(i_rst_b) |-> !o_fast_acquire_enable)
      else $error("Fast acquisition was on after reset.");

   sel_split_a: assert property (
      wr_hit(i_req, CMS_SEL_HIGH_ADDR)
      |=> ##1 (o_mon_cfg.los_normal_en | o_mon_cfg.los_slow_en)
          == $past(i_req.wdata[3:0], 2))
      else $error("Upper selector bits did not gate signal-loss monitors.");

   sel_slow_code_a: assert property (
      (sel_high_q[2] && !sel_low_fos_q[6])
      |=> o_mon_cfg.los_slow_en[2] && !o_mon_cfg.los_normal_en[2])
      else $error("Selector 10 did not pick the slow detector.");

   fos_enable_a: assert property (
      wr_hit(i_req, CMS_SEL_LOW_ADDR)
      |=> ##1 o_mon_cfg.fos_en == $past(i_req.wdata[3:0], 2))
      else $error("Offset-monitor enables did not follow the write.");

   mon_reset_a: assert property (disable iff (1'b0)
      $rose(i_rst_b) |-> o_mon_cfg.fos_en == 4'hf
         && o_mon_cfg.los_normal_en == 4'hf && sel_low_fos_q == 8'hff)
      else $error("Monitors did not start in normal mode with offset on.");

   trim_signed_a: assert property (
      wr_hit(i_req, CMS_TRIM1_ADDR)
      |=> o_output1_phase_trim == $signed($past(i_req.wdata)))
      else $error("Output one trim did not take the signed byte.");

   trim_load_a: assert property (
      wr_hit(i_req, CMS_TRIM2_ADDR) && !wr_hit(i_req, CMS_TRIM1_ADDR)
      |=> o_phase_trim_load == 2'b10 ##1 o_phase_trim_load[1] == 1'b0
          || wr_hit($past(i_req), CMS_TRIM2_ADDR))
      else $error("Output two trim load pulse wrong.");

   trim2_reset_a: assert property (disable iff (1'b0)
      $rose(i_rst_b) |-> o_output2_phase_trim == 8'sd1)
      else $error("Output two trim did not reset to plus one.");

   rsvd_read_a: assert property (
      i_req.rd && i_req.addr == CMS_SEL_HIGH_ADDR
      |=> o_reg_rvalid && o_reg_rdata[7:4] == 4'h0)
      else $error("Reserved selector bits read non-zero.");

   unmapped_read_a: assert property (
      i_req.rd && (i_req.addr < CMS_FAST_ACQ_ADDR
                   || i_req.addr > CMS_TRIM2_ADDR)
      |=> o_reg_rdata == 8'h00)
      else $error("Unmapped offset did not read zero.");

   // Register-level checks compare outputs against the stored bytes, so
   // a broken decode or a stray write shows up in the very next cycle.

   trim2_write_a: assert property (
      wr_hit(i_req, CMS_TRIM2_ADDR)
      |=> o_output2_phase_trim == $signed($past(i_req.wdata)))
      else $error("Output two trim did not take the signed byte.");

   trim2_hold_a: assert property (
      !wr_hit(i_req, CMS_TRIM2_ADDR)
      |=> $stable(o_output2_phase_trim))
      else $error("Output two trim moved without a write.");

   fast_acq_hold_a: assert property (
      !wr_hit(i_req, CMS_FAST_ACQ_ADDR)
      |=> $stable(o_fast_acquire_enable))
      else $error("Fast acquisition moved without a write.");

   slow_map_a: assert property (
      1'b1 |=> o_mon_cfg.los_slow_en == ($past(sel_high_q)
         & ~$past(sel_low_fos_q[CMS_SEL_LOW_LSB +: 4])))
      else $error("Slow detector enables do not match code 10.");

   normal_map_a: assert property (
      1'b1 |=> o_mon_cfg.los_normal_en == ($past(sel_high_q)
         & $past(sel_low_fos_q[CMS_SEL_LOW_LSB +: 4])))
      else $error("Normal detector enables do not match code 11.");

   sel_low_read_a: assert property (
      i_req.rd && i_req.addr == CMS_SEL_LOW_ADDR
      |=> o_reg_rdata == $past(sel_low_fos_q))
      else $error("Low selector register read back wrong.");

   trim1_read_a: assert property (
      i_req.rd && i_req.addr == CMS_TRIM1_ADDR
      |=> o_reg_rdata == $past(trim1_q))
      else $error("Output one trim read back wrong.");

   fast_acq_rsvd_a: assert property (
      i_req.rd && i_req.addr == CMS_FAST_ACQ_ADDR
      |=> o_reg_rdata[7:1] == 7'h00)
      else $error("Reserved fast-acquire bits read non-zero.");

   unmapped_write_a: assert property (
      i_req.wr && (i_req.addr < CMS_FAST_ACQ_ADDR
                   || i_req.addr > CMS_TRIM2_ADDR)
      |=> $stable(trim1_q) && $stable(trim2_q) && $stable(sel_high_q)
          && $stable(sel_low_fos_q) && $stable(fast_acquire_q))
      else $error("Write to an unmapped offset changed a register.");

   read_answer_a: assert property (
      i_req.rd |=> o_reg_rvalid)
      else $error("Read was not answered in the next cycle.");

   trim_load_idle_a: assert property (
      !wr_hit(i_req, CMS_TRIM1_ADDR) |=> !o_phase_trim_load[0])
      else $error("Output one load pulse without a write.");

   // Main scenarios that the bench is expected to reach.
   fast_acq_on_c: cover property ($rose(o_fast_acquire_enable));
   slow_sel_c: cover property (o_mon_cfg.los_slow_en != 4'h0);
   neg_trim_c: cover property (o_output1_phase_trim < 0);
   read_low_c: cover property (
      i_req.rd && i_req.addr == CMS_SEL_LOW_ADDR ##1 o_reg_rvalid);
   sel_off_c: cover property (
      (o_mon_cfg.los_normal_en | o_mon_cfg.los_slow_en) != 4'hf);

endmodule : cms_regs

`default_nettype wire

//--- testbench/cms_regs_tb.sv
// Self-checking testbench for the clock-monitor and phase-trim registers.
// Assumes the decoded register port of cms_regs and a 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module testbench
   import cms_pkg::*;
;
   // ----------------------------------------------------------------------
   // Signals and instance
   // ----------------------------------------------------------------------
   logic              i_clk;
   logic              i_rst_b;
   cms_reg_req_type   i_req;
   logic [7:0]        o_reg_rdata;
   logic              o_reg_rvalid;
   logic              o_fast_acquire_enable;
   cms_mon_cfg_type   o_mon_cfg;
   logic signed [7:0] o_output1_phase_trim;
   logic signed [7:0] o_output2_phase_trim;
   logic [1:0]        o_phase_trim_load;
   int                n_errors;
   int                comparisons;

   cms_regs cms_regs_i (
      .i_clk                 (i_clk),
      .i_rst_b               (i_rst_b),
      .i_req                 (i_req),
      .o_reg_rdata           (o_reg_rdata),
      .o_reg_rvalid          (o_reg_rvalid),
      .o_fast_acquire_enable (o_fast_acquire_enable),
      .o_mon_cfg             (o_mon_cfg),
      .o_output1_phase_trim  (o_output1_phase_trim),
      .o_output2_phase_trim  (o_output2_phase_trim),
      .o_phase_trim_load     (o_phase_trim_load)
   );

   // The clock toggles every half period of 2.5 ns.
   initial i_clk = 1'b0;
   always #2.5 i_clk = ~i_clk;

   // ----------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------
   // Compares one value, counts it and reports a mismatch at once.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Holds reset low for five cycles, releasing it just after an edge.
   task automatic do_reset();
      @(posedge i_clk);
      #1 i_rst_b = 1'b0;
      repeat (5) @(posedge i_clk);
      #1 i_rst_b = 1'b1;
   endtask : do_reset

   // One write; returns just after the taking edge.
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      @(posedge i_clk);
      #1 i_req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
      @(posedge i_clk);
      #1 i_req = '0;
   endtask : wr

   // One read; the answer stands in the cycle after the taking edge.
   task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
      @(posedge i_clk);
      #1 i_req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
      @(posedge i_clk);
      #1 i_req = '0;
      chk(16'(o_reg_rvalid), 16'h0001);
      chk(16'(o_reg_rdata), 16'(exp));
   endtask : rd

   // Verdict; the only place where the run ends.
   task automatic summarize();
      if (n_errors == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   // Fast acquire, monitor enables, output two trim and load pulses, then three registers by read, show their defaults after reset.
   task automatic check_defaults();
      chk(16'(o_fast_acquire_enable), 16'h0000);
      chk(16'(o_mon_cfg), 16'h0f0f);
      chk(16'(o_output2_phase_trim), 16'h0001);
      chk(16'(o_phase_trim_load), 16'h0000);
      rd(CMS_FAST_ACQ_ADDR, 8'h00);
      rd(CMS_SEL_LOW_ADDR, 8'hff);
      rd(CMS_TRIM2_ADDR, 8'h01);
   endtask : check_defaults

   // Only bit 0 of the fast-acquire register is stored.
   task automatic fast_acquire();
      wr(CMS_FAST_ACQ_ADDR, 8'hff);
      chk(16'(o_fast_acquire_enable), 16'h0001);
      rd(CMS_FAST_ACQ_ADDR, 8'h01);
      wr(CMS_FAST_ACQ_ADDR, 8'hfe);
      chk(16'(o_fast_acquire_enable), 16'h0000);
      rd(CMS_FAST_ACQ_ADDR, 8'h00);
   endtask : fast_acquire

   // Each input walks through the legal selector codes by rotation; the
   // reserved code is never written, it is replaced by off.
   task automatic selector_codes();
      logic [3:0] hi;
      logic [3:0] lo;
      logic [3:0] frequency_offset_detector;
      logic [3:0] norm;
      logic [3:0] slow;
      logic [1:0] sel;
      for (int c = 0; c < 4; c++) begin
         for (int n = 0; n < 4; n++) begin
            sel = 2'(c + n);
            if (sel == CMS_SEL_RSVD) begin
               sel = CMS_SEL_OFF;
            end
            hi[n] = sel[1];
            lo[n] = sel[0];
            norm[n] = (sel == 2'b11);
            slow[n] = (sel == 2'b10);
         end
         frequency_offset_detector = 4'(4'h1 << c) ^ 4'ha;
         wr(CMS_SEL_HIGH_ADDR, {4'hf, hi});
         wr(CMS_SEL_LOW_ADDR, {lo, frequency_offset_detector});
         @(posedge i_clk);
         #1 chk(16'(o_mon_cfg), 16'({norm, slow, frequency_offset_detector}));
         rd(CMS_SEL_HIGH_ADDR, {4'h0, hi});
         rd(CMS_SEL_LOW_ADDR, {lo, frequency_offset_detector});
      end
   endtask : selector_codes

   // Back-to-back trim writes; the first shares its cycle with a read.
   task automatic phase_trims();
      @(posedge i_clk);
      #1 i_req = '{wr: 1'b1, rd: 1'b1, addr: CMS_TRIM1_ADDR, wdata: 8'h80};
      @(posedge i_clk);
      #1 i_req = '{wr: 1'b1, rd: 1'b0, addr: CMS_TRIM2_ADDR, wdata: 8'h7f};
      chk(16'(o_reg_rdata), 16'h0000);
      chk(16'($signed(o_output1_phase_trim)), 16'hff80);
      chk(16'(o_phase_trim_load), 16'h0001);
      @(posedge i_clk);
      #1 i_req = '0;
      chk(16'($signed(o_output2_phase_trim)), 16'h007f);
      chk(16'(o_output1_phase_trim), 16'hff80);
      chk(16'(o_phase_trim_load), 16'h0002);
      @(posedge i_clk);
      #1 chk(16'(o_phase_trim_load), 16'h0000);
      rd(CMS_TRIM1_ADDR, 8'h80);
   endtask : phase_trims

   // Unmapped places store nothing and read as zero.
   task automatic unmapped();
      wr(8'h88, 8'h5a);
      wr(8'h8e, 8'h5a);
      rd(8'h88, 8'h00);
      rd(8'h8e, 8'h00);
      rd(CMS_TRIM2_ADDR, 8'h7f);
   endtask : unmapped

   // ----------------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------------
   // Runs the scenarios, then resets in mid-run and checks defaults again.
   initial begin
      n_errors = 0;
      comparisons = 0;
      i_rst_b = 1'b0;
      i_req = '0;
      do_reset();
      check_defaults();
      fast_acquire();
      selector_codes();
      phase_trims();
      unmapped();
      wr(CMS_FAST_ACQ_ADDR, 8'h01);
      do_reset();
      check_defaults();
      summarize();
   end

   // Cuts a hang short; the run needs well under 2 us.
   initial begin
      #20000;
      n_errors++;
      summarize();
   end

endmodule : testbench

`default_nettype wire
